// ### src/bsc_pkg.sv
// Package with constants and types for the bus snooping CRC engine.
package bsc_pkg;
    localparam int BSC_AW = 32;
    localparam int BSC_DW = 32;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SEL_CRC_EIGHT_BIT = 2'h0;
    localparam logic [1:0] SEL_CRC16_FIRST = 2'h1;
    localparam logic [1:0] SEL_CRC16_SECOND = 2'h2;
    localparam logic [1:0] SEL_CRC_THIRTYTWO_BIT = 2'h3;
    localparam logic [31:0] POLY_CRC_EIGHT_BIT = 32'h0000_0007;
    localparam logic [31:0] POLY_CRC16_FIRST = 32'h0000_8005;
    localparam logic [31:0] POLY_CRC16_SECOND = 32'h0000_1021;
    localparam logic [31:0] POLY_CRC_THIRTYTWO_BIT = 32'h04c1_1db7;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam int BSC_ZW = 2;
    localparam logic [31:0] MIRROR_BASE_DEF = 32'h0100_0000;
    localparam logic [31:0] MIRROR_MASK_DEF = 32'hff00_0000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FOLD = 2'b10
    } bsc_state_t;
endpackage

// ### src/bsc_crc_engine.sv
// Bus snooping CRC engine that folds mirrored byte reads into a result register.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Snoop reads on code and system buses.
// - Capture only reads in mirrored alias region.
// - Fold captured byte into result register.
// - Result readable anytime, reflects bytes since clear.
// - Only byte reads contribute.
// - Half-word and word reads leave result unchanged.
// - Debugger reads do not alter result.
// - 8-bit CRC with polynomial 0x07.
// - 16-bit CRCs with 0x8005 and 0x1021.
// - 32-bit CRC with polynomial 0x04C11DB7.
// - Writing one to clear zeroes result.
// - Selector register picks one of four polynomials.
// - Result register accepts software writes for restore.
// - Reads of other zone memory yield no CRC.
// - Execute-only sectors count only from same zone.
// - Execute-only data goes to engine, not processor.
module bsc_crc_engine
    import bsc_pkg::*;
#(
    parameter logic [31:0] MIRROR_BASE = bsc_pkg::MIRROR_BASE_DEF,
    parameter logic [31:0] MIRROR_MASK = bsc_pkg::MIRROR_MASK_DEF
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic code_rd_valid,
    input wire logic [bsc_pkg::BSC_AW-1:0] code_rd_addr,
    input wire logic [1:0] code_rd_size,
    input wire logic [bsc_pkg::BSC_DW-1:0] code_rd_data,
    input wire logic code_rd_debug,
    input wire logic [bsc_pkg::BSC_ZW-1:0] code_rd_mem_zone,
    input wire logic [bsc_pkg::BSC_ZW-1:0] code_rd_exec_zone,
    input wire logic code_rd_exe_only,
    output logic [bsc_pkg::BSC_DW-1:0] code_cpu_data,
    input wire logic sys_rd_valid,
    input wire logic [bsc_pkg::BSC_AW-1:0] sys_rd_addr,
    input wire logic [1:0] sys_rd_size,
    input wire logic [bsc_pkg::BSC_DW-1:0] sys_rd_data,
    input wire logic sys_rd_debug,
    input wire logic [bsc_pkg::BSC_ZW-1:0] sys_rd_mem_zone,
    input wire logic [bsc_pkg::BSC_ZW-1:0] sys_rd_exec_zone,
    input wire logic sys_rd_exe_only,
    output logic [bsc_pkg::BSC_DW-1:0] sys_cpu_data,
    input wire logic crc_control_clear,
    input wire logic crc_poly_select_wr,
    input wire logic [1:0] crc_poly_select_wdata,
    output logic [1:0] crc_poly_select_reg,
    input wire logic crc_result_wr,
    input wire logic [31:0] crc_result_wdata,
    output logic [31:0] crc_result_reg,
    output logic crc_busy
);
    import bsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    function automatic logic [31:0] width_mask(input logic [1:0] sel);
        logic [31:0] m;
        m = 32'hffff_ffff;
        case (sel)
            SEL_CRC_EIGHT_BIT: m = 32'h0000_00ff;
            SEL_CRC16_FIRST: m = 32'h0000_ffff;
            SEL_CRC16_SECOND: m = 32'h0000_ffff;
            default: m = 32'hffff_ffff;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] poly_of(input logic [1:0] sel);
        logic [31:0] p;
        p = POLY_CRC_THIRTYTWO_BIT;
        case (sel)
            SEL_CRC_EIGHT_BIT: p = POLY_CRC_EIGHT_BIT;
            SEL_CRC16_FIRST: p = POLY_CRC16_FIRST;
            SEL_CRC16_SECOND: p = POLY_CRC16_SECOND;
            default: p = POLY_CRC_THIRTYTWO_BIT;
        endcase
        return p;
    endfunction

    // Non-reflected MSB-first CRC of one byte over a register of the selected width.
    function automatic logic [31:0] crc_byte(input logic [31:0] cur, input logic [7:0] b,
                                             input logic [1:0] sel);
        logic [31:0] c;
        logic [31:0] p;
        logic [31:0] m;
        logic [31:0] top;
        logic fb;
        m = width_mask(sel);
        p = poly_of(sel);
        c = cur & m;
        top = (m >> 1) + 32'h0000_0001;
        for (int i = 7; i >= 0; i--) begin
            fb = ((c & top) != 32'h0000_0000) ^ b[i];
            c = (c << 1) & m;
            if (fb) begin
                c = c ^ p;
            end
        end
        return c & m;
    endfunction

    // A snooped read qualifies for folding.
    function automatic logic qualifies(input logic v, input logic [31:0] a, input logic [1:0] sz,
                                       input logic dbg, input logic [1:0] mz,
                                       input logic [1:0] ez);
        return v && ((a & MIRROR_MASK) == MIRROR_BASE) && (sz == SIZE_BYTE) && !dbg
               && (mz == ez);
    endfunction

    function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [1:0] a);
        return d[{a, 3'h0} +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Snoop qualification.

    logic code_hit;
    logic sys_hit;
    assign code_hit = qualifies(code_rd_valid, code_rd_addr, code_rd_size, code_rd_debug,
                                code_rd_mem_zone, code_rd_exec_zone);
    assign sys_hit = qualifies(sys_rd_valid, sys_rd_addr, sys_rd_size, sys_rd_debug,
                               sys_rd_mem_zone, sys_rd_exec_zone);

    ////////////////////////////////////////////////////////////////////////////////
    // Data returned to the processor.

    logic [31:0] next_code_cpu_data;
    logic [31:0] next_sys_cpu_data;

    always_comb begin
        next_code_cpu_data = code_cpu_data;
        next_sys_cpu_data = sys_cpu_data;
        if (code_rd_valid) begin
            next_code_cpu_data = code_rd_data;
            // blocked or execute-only reads return zero
            if (code_rd_exe_only || (code_rd_mem_zone != code_rd_exec_zone)) begin
                next_code_cpu_data = 32'h0000_0000;
            end
        end
        if (sys_rd_valid) begin
            next_sys_cpu_data = sys_rd_data;
            // blocked or execute-only reads return zero
            if (sys_rd_exe_only || (sys_rd_mem_zone != sys_rd_exec_zone)) begin
                next_sys_cpu_data = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            code_cpu_data <= 32'h0000_0000;
            sys_cpu_data <= 32'h0000_0000;
        end else begin
            code_cpu_data <= next_code_cpu_data;
            sys_cpu_data <= next_sys_cpu_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result register and polynomial selector.

    logic [31:0] crc_acc;
    logic [31:0] next_crc_acc;
    logic [1:0] next_poly_sel;
    logic [31:0] after_code;
    logic [31:0] after_sys;
    bsc_state_t state;
    bsc_state_t next_state;

    always_comb begin
        next_poly_sel = crc_poly_select_reg;
        if (crc_poly_select_wr) begin
            next_poly_sel = crc_poly_select_wdata;
        end
        // fold code byte first, then system byte
        after_code = code_hit ? crc_byte(crc_acc, lane_byte(code_rd_data, code_rd_addr[1:0]),
                                         crc_poly_select_reg) : crc_acc;
        after_sys = sys_hit ? crc_byte(after_code, lane_byte(sys_rd_data, sys_rd_addr[1:0]),
                                       crc_poly_select_reg) : after_code;
        next_crc_acc = after_sys;
        next_state = (code_hit || sys_hit) ? ST_FOLD : ST_IDLE;
        // Software writes take priority over snooped bytes in the same cycle.
        // restore saved value
        if (crc_result_wr) begin
            next_crc_acc = crc_result_wdata;
        end
        if (crc_control_clear) begin
            next_crc_acc = RESULT_RESET;
        end
        case (state)
            ST_IDLE: crc_busy = 1'b0;
            ST_FOLD: crc_busy = 1'b1;
            default: crc_busy = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            crc_acc <= RESULT_RESET;
            crc_poly_select_reg <= SEL_RESET;
            state <= ST_IDLE;
        end else begin
            crc_acc <= next_crc_acc;
            crc_poly_select_reg <= next_poly_sel;
            state <= next_state;
        end
    end

    // readable any time, masked to selected width
    assign crc_result_reg = crc_acc & width_mask(crc_poly_select_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_quiet;
        !crc_result_wr && !crc_control_clear && !crc_poly_select_wr;
    endsequence

    AST_CLEAR_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        crc_control_clear |=> crc_result_reg == 32'h0000_0000)
        else $error("clear did not zero result");
    AST_RESTORE: assert property (@(posedge mclk) disable iff (!rstn)
        crc_result_wr && !crc_control_clear |=> crc_acc == $past(crc_result_wdata))
        else $error("restore value not taken");
    AST_NO_HIT_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        (!code_hit && !sys_hit) and s_quiet |=> $stable(crc_acc))
        else $error("result changed without qualifying read");
    AST_WIDE_IGNORED: assert property (@(posedge mclk) disable iff (!rstn)
        ((code_rd_size != SIZE_BYTE) && !sys_hit) and s_quiet |=> $stable(crc_acc))
        else $error("wide read altered result");
    AST_DEBUG_IGNORED: assert property (@(posedge mclk) disable iff (!rstn)
        (code_rd_valid && code_rd_debug && !sys_hit) and s_quiet |=> $stable(crc_acc))
        else $error("debugger read altered result");
    AST_CRC_EIGHT_BIT_MASK: assert property (@(posedge mclk) disable iff (!rstn)
        crc_poly_select_reg == SEL_CRC_EIGHT_BIT |-> crc_result_reg[31:8] == 24'h00_0000)
        else $error("upper bits not zero for 8-bit crc");
    AST_CRC_EIGHT_BIT_STEP: assert property (@(posedge mclk) disable iff (!rstn)
        (code_hit && !sys_hit && crc_poly_select_reg == SEL_CRC_EIGHT_BIT
        && code_rd_addr[1:0] == 2'h0 && code_rd_data[7:0] == 8'h01 && crc_result_reg == 32'h0)
        and s_quiet |=> crc_result_reg == 32'h0000_0007)
        else $error("crc_eight_bit of one byte wrong");
    AST_CRC_THIRTYTWO_BIT_STEP: assert property (@(posedge mclk) disable iff (!rstn)
        (sys_hit && !code_hit && crc_poly_select_reg == SEL_CRC_THIRTYTWO_BIT
        && sys_rd_addr[1:0] == 2'h0 && sys_rd_data[7:0] == 8'h01 && crc_acc == 32'h0)
        and s_quiet |=> crc_result_reg == 32'h04c1_1db7)
        else $error("crc_thirtytwo_bit of one byte wrong");
    AST_EXE_ONLY_HIDDEN: assert property (@(posedge mclk) disable iff (!rstn)
        code_rd_valid && code_rd_exe_only |=> code_cpu_data == 32'h0000_0000)
        else $error("execute-only data reached processor");
    AST_ZONE_BLOCK: assert property (@(posedge mclk) disable iff (!rstn)
        (sys_rd_valid && (sys_rd_mem_zone != sys_rd_exec_zone) && !code_hit) and s_quiet
        |=> $stable(crc_acc) && sys_cpu_data == 32'h0000_0000)
        else $error("other-zone read not blocked");

    // Busy follows a fold by one cycle; it rises in the same cycle that the folded result becomes visible.
    sequence s_fold;
        code_hit || sys_hit;
    endsequence

    AST_BUSY_FOLD: assert property (@(posedge mclk) disable iff (!rstn)
        s_fold |=> crc_busy)
        else $error("busy not raised after fold");
    AST_BUSY_QUIET: assert property (@(posedge mclk) disable iff (!rstn)
        !code_hit && !sys_hit |=> !crc_busy)
        else $error("busy raised without fold");

    // The selector only moves on a write, so a running calculation keeps its width.
    AST_SEL_TAKEN: assert property (@(posedge mclk) disable iff (!rstn)
        crc_poly_select_wr |=> crc_poly_select_reg == $past(crc_poly_select_wdata))
        else $error("selector write not taken");
    AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        !crc_poly_select_wr |=> $stable(crc_poly_select_reg))
        else $error("selector changed without write");
    AST_CRC16_MASK: assert property (@(posedge mclk) disable iff (!rstn)
        crc_poly_select_reg == SEL_CRC16_FIRST || crc_poly_select_reg == SEL_CRC16_SECOND
        |-> crc_result_reg[31:16] == 16'h0000)
        else $error("upper bits not zero for 16-bit crc");

    // System bus twins of the code bus checks above, plus plain data return.
    AST_SYS_WIDE_IGNORED: assert property (@(posedge mclk) disable iff (!rstn)
        ((sys_rd_size != SIZE_BYTE) && !code_hit) and s_quiet |=> $stable(crc_acc))
        else $error("wide system read altered result");
    AST_SYS_DEBUG_IGNORED: assert property (@(posedge mclk) disable iff (!rstn)
        (sys_rd_valid && sys_rd_debug && !code_hit) and s_quiet |=> $stable(crc_acc))
        else $error("debugger system read altered result");
    AST_SYS_EXE_HIDDEN: assert property (@(posedge mclk) disable iff (!rstn)
        sys_rd_valid && sys_rd_exe_only |=> sys_cpu_data == 32'h0000_0000)
        else $error("execute-only data reached processor on system bus");
    AST_CODE_DATA_PASS: assert property (@(posedge mclk) disable iff (!rstn)
        code_rd_valid && !code_rd_exe_only && (code_rd_mem_zone == code_rd_exec_zone)
        |=> code_cpu_data == $past(code_rd_data))
        else $error("permitted read data not returned");
    AST_CODE_DATA_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        !code_rd_valid |=> $stable(code_cpu_data))
        else $error("returned data changed without a read");
endmodule
`default_nettype wire

// ### verif/bsc_host_bus.sv
// Host bus model that issues snooped reads on one processor bus.
`timescale 1ns/10ps
`default_nettype none
module bsc_host_bus
    import bsc_pkg::*;
(
    input wire logic mclk,
    output logic rd_valid,
    output logic [bsc_pkg::BSC_AW-1:0] rd_addr,
    output logic [1:0] rd_size,
    output logic [bsc_pkg::BSC_DW-1:0] rd_data,
    output logic rd_debug,
    output logic [bsc_pkg::BSC_ZW-1:0] rd_mem_zone,
    output logic [bsc_pkg::BSC_ZW-1:0] rd_exec_zone,
    output logic rd_exe_only
);
    initial begin
        {rd_valid, rd_addr, rd_size, rd_data, rd_debug} = '0;
        {rd_mem_zone, rd_exec_zone, rd_exe_only} = '0;
    end
    // one read per call
    // Idle data is inverted so a stale byte can never look like a fresh one.
    task automatic rd(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] d,
                      input logic [5:0] attr);
        @(posedge mclk);
        rd_valid <= 1'b1;
        rd_addr <= a;
        rd_size <= sz;
        rd_data <= d;
        {rd_exe_only, rd_debug, rd_mem_zone, rd_exec_zone} <= attr;
        @(posedge mclk);
        rd_valid <= 1'b0;
        rd_data <= ~d;
    endtask
endmodule
`default_nettype wire

// ### verif/bsc_crc_engine_bench.sv
// Self-checking bench for the bus snooping CRC engine.
`timescale 1ns/10ps
`default_nettype none
module bsc_crc_engine_bench;
    import bsc_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic clr = 1'b0;
    logic sel_wr = 1'b0;
    logic [1:0] sel_wd = 2'h0;
    logic res_wr = 1'b0;
    logic [31:0] res_wd = 32'h0;
    logic c_v, c_dbg, c_xo, s_v, s_dbg, s_xo, busy;
    logic [1:0] c_sz, c_mz, c_ez, s_sz, s_mz, s_ez, sel;
    logic [31:0] c_a, c_d, s_a, s_d, c_cpu, s_cpu, res, e;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    always #2.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    bsc_host_bus code_host (.mclk(mclk), .rd_valid(c_v), .rd_addr(c_a), .rd_size(c_sz),
        .rd_data(c_d), .rd_debug(c_dbg), .rd_mem_zone(c_mz), .rd_exec_zone(c_ez),
        .rd_exe_only(c_xo));
    bsc_host_bus sys_host (.mclk(mclk), .rd_valid(s_v), .rd_addr(s_a), .rd_size(s_sz),
        .rd_data(s_d), .rd_debug(s_dbg), .rd_mem_zone(s_mz), .rd_exec_zone(s_ez),
        .rd_exe_only(s_xo));
    bsc_crc_engine DUT (.mclk(mclk), .rstn(rstn),
        .code_rd_valid(c_v), .code_rd_addr(c_a), .code_rd_size(c_sz), .code_rd_data(c_d),
        .code_rd_debug(c_dbg), .code_rd_mem_zone(c_mz), .code_rd_exec_zone(c_ez),
        .code_rd_exe_only(c_xo), .code_cpu_data(c_cpu),
        .sys_rd_valid(s_v), .sys_rd_addr(s_a), .sys_rd_size(s_sz), .sys_rd_data(s_d),
        .sys_rd_debug(s_dbg), .sys_rd_mem_zone(s_mz), .sys_rd_exec_zone(s_ez),
        .sys_rd_exe_only(s_xo), .sys_cpu_data(s_cpu),
        .crc_control_clear(clr), .crc_poly_select_wr(sel_wr), .crc_poly_select_wdata(sel_wd),
        .crc_poly_select_reg(sel), .crc_result_wr(res_wr), .crc_result_wdata(res_wd),
        .crc_result_reg(res), .crc_busy(busy));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] crc_ref(input logic [1:0] s, input logic [31:0] acc,
                                            input logic [7:0] b);
        int w;
        logic [31:0] p;
        logic [31:0] m;
        w = (s == SEL_CRC_EIGHT_BIT) ? 8 : (s == SEL_CRC_THIRTYTWO_BIT) ? 32 : 16;
        p = (s == SEL_CRC_EIGHT_BIT) ? POLY_CRC_EIGHT_BIT : (s == SEL_CRC16_FIRST) ? POLY_CRC16_FIRST :
            (s == SEL_CRC16_SECOND) ? POLY_CRC16_SECOND : POLY_CRC_THIRTYTWO_BIT;
        m = (w == 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
        acc = (acc & m) ^ ({24'h0, b} << (w - 8));
        for (int i = 0; i < 8; i++) begin
            acc = acc[w-1] ? ((acc << 1) ^ p) : (acc << 1);
        end
        return acc & m;
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask
    task automatic ctl(input logic [1:0] k, input logic [31:0] v);
        @(posedge mclk);
        {clr, sel_wr, res_wr} <= {k == 2'h0, k == 2'h1, k == 2'h2};
        sel_wd <= v[1:0];
        res_wd <= v;
        @(posedge mclk);
        {clr, sel_wr, res_wr} <= 3'h0;
        @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_polys();
        for (int s = 0; s < 4; s++) begin
            ctl(2'h0, 32'h0);
            ctl(2'h1, s);
            chk("selector", s, {30'h0, sel});
            code_host.rd(32'h0100_0003, SIZE_BYTE, 32'h5a00_0000, 6'h05);
            @(negedge mclk);
            e = crc_ref(s[1:0], 32'h0, 8'h5a);
            chk("code byte crc", e, res);
            sys_host.rd(32'h0100_0010, SIZE_BYTE, 32'h0000_00c3, 6'h05);
            @(negedge mclk);
            chk("sys byte crc", crc_ref(s[1:0], e, 8'hc3), res);
        end
    endtask
    task automatic t_refuse();
        ctl(2'h1, {30'h0, SEL_CRC_THIRTYTWO_BIT});
        ctl(2'h2, 32'h1234_5678);
        for (int i = 0; i < 5; i++) begin
            code_host.rd((i == 0) ? 32'h0200_0000 : 32'h0100_0000,
                (i == 1) ? SIZE_HALF : (i == 2) ? SIZE_WORD : SIZE_BYTE, 32'h0000_0099,
                (i == 3) ? 6'h15 : (i == 4) ? 6'h06 : 6'h05);
            @(negedge mclk);
            chk("refused read", 32'h1234_5678, res);
        end
        chk("cpu data other zone", 32'h0, c_cpu);
    endtask
    task automatic t_both();
        ctl(2'h0, 32'h0);
        ctl(2'h1, {30'h0, SEL_CRC16_SECOND});
        fork
            code_host.rd(32'h0100_0000, SIZE_BYTE, 32'h0000_0011, 6'h05);
            sys_host.rd(32'h0100_0001, SIZE_BYTE, 32'h0000_2200, 6'h25);
        join
        @(negedge mclk);
        e = crc_ref(SEL_CRC16_SECOND, crc_ref(SEL_CRC16_SECOND, 32'h0, 8'h11), 8'h22);
        chk("same cycle crc", e, res);
        chk("cpu data normal", 32'h0000_0011, c_cpu);
        chk("cpu data exe only", 32'h0, s_cpu);
    endtask
    task automatic t_restore();
        ctl(2'h1, {30'h0, SEL_CRC_EIGHT_BIT});
        ctl(2'h2, 32'hffff_ffff);
        chk("masked result", 32'h0000_00ff, res);
        ctl(2'h1, {30'h0, SEL_CRC16_FIRST});
        ctl(2'h2, 32'h0000_abcd);
        sys_host.rd(32'h0100_0020, SIZE_BYTE, 32'h0000_0077, 6'h0a);
        @(negedge mclk);
        chk("restored crc", crc_ref(SEL_CRC16_FIRST, 32'h0000_abcd, 8'h77), res);
        ctl(2'h0, 32'h0);
        chk("cleared", 32'h0, res);
    endtask
    task automatic t_walk();
        ctl(2'h0, 32'h0);
        ctl(2'h1, {30'h0, SEL_CRC_EIGHT_BIT});
        code_host.rd(32'h0100_0000, SIZE_BYTE, 32'h0000_0001, 6'h25);
        @(negedge mclk);
        chk("crc_eight_bit one byte", POLY_CRC_EIGHT_BIT, res);
        chk("busy after fold", 32'h1, {31'h0, busy});
        chk("cpu data exe only code", 32'h0, c_cpu);
        @(negedge mclk);
        chk("busy idle", 32'h0, {31'h0, busy});
        ctl(2'h0, 32'h0);
        ctl(2'h1, {30'h0, SEL_CRC_THIRTYTWO_BIT});
        sys_host.rd(32'h0100_0000, SIZE_BYTE, 32'h0000_0001, 6'h05);
        @(negedge mclk);
        chk("crc_thirtytwo_bit one byte", POLY_CRC_THIRTYTWO_BIT, res);
        sys_host.rd(32'h0100_0004, SIZE_BYTE, 32'h0000_0055, 6'h06);
        @(negedge mclk);
        chk("sys other zone crc", POLY_CRC_THIRTYTWO_BIT, res);
        chk("sys other zone cpu", 32'h0, s_cpu);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // The run needs under a hundred cycles; the ceiling of 3000 leaves ample margin.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        chk("result after reset", RESULT_RESET, res);
        chk("selector after reset", {30'h0, SEL_RESET}, {30'h0, sel});
        t_polys();
        t_refuse();
        t_both();
        t_restore();
        t_walk();
        wrap_up();
    end
endmodule
`default_nettype wire
